// File: pirl_pkg.sv
/*
  Shared constants and types of the per-port, per-priority ingress rate
  limit block: register index map, field positions, reset values, rate
  table figures and the carrier structs.
  Assumes a 32-bit classic Wishbone master with byte addresses.
*/
package pirl_pkg;

  localparam int PORT_CNT = 7;
  localparam int PRIO_CNT = 8;
  localparam int CODE_W = 7;
  localparam int RATE_W = 24;
  localparam int WB_ADR_W = 18;
  localparam int WB_DAT_W = 32;

  // Register index = byte address / 4; index bits 15:12 hold the port
  localparam int IDX_LSB = 2;
  localparam int IDX_PORT_LSB = 12;
  localparam int IDX_PORT_W = 4;
  localparam int IDX_SUB_W = 12;
  localparam int IDX_PRIO_W = 3;
  localparam logic [IDX_PORT_W-1:0] PORT_FIRST = 4'h1;
  localparam logic [IDX_PORT_W-1:0] PORT_LAST = 4'h7;
  localparam logic [IDX_SUB_W-1:0] SUB_CTRL = 12'h403;
  localparam logic [IDX_SUB_W-1:0] SUB_PRIO0 = 12'h410;
  localparam logic [IDX_SUB_W-1:0] SUB_STATUS = 12'h418;
  localparam logic [IDX_PRIO_W-1:0] PRIO_COMMIT = 3'h7;

  // Field positions
  localparam int CTRL_PORT_BASED_BIT = 6;
  localparam int CTRL_PKT_MODE_BIT = 5;
  localparam int STATUS_PENDING_BIT = 0;
  localparam logic [CODE_W-1:0] CODE_RESET = 7'h00;

  // Rate code ranges
  localparam logic [CODE_W-1:0] CODE_FULL = 7'h00;
  localparam logic [CODE_W-1:0] CODE_LOW_MAX = 7'h0a;
  localparam logic [CODE_W-1:0] CODE_MID_MAX = 7'h64;
  localparam logic [CODE_W-1:0] CODE_DEF_MAX = 7'h73;
  localparam logic [RATE_W-1:0] CODE_FINE_BASE = 24'h000064;
  localparam logic [RATE_W-1:0] FINE_COARSE_MAX = 24'h000003;

  // Rate figures: bit column in kbps, packet column in packets/s
  localparam logic [RATE_W-1:0] KBPS_1M = 24'h0003e8;
  localparam logic [RATE_W-1:0] KBPS_10M = 24'h002710;
  localparam logic [RATE_W-1:0] KBPS_100M = 24'h0186a0;
  localparam logic [RATE_W-1:0] KBPS_1G = 24'h0f4240;
  localparam logic [RATE_W-1:0] PKTS_10M = 24'h004b00;
  localparam logic [RATE_W-1:0] PKTS_100M = 24'h02ee00;
  localparam logic [RATE_W-1:0] PKTS_1G = 24'h1d4c00;
  localparam logic [RATE_W-1:0] PKTS_STEP = 24'h000780;
  localparam logic [RATE_W-1:0] FINE_STEP = 24'h000040;
  localparam logic [RATE_W-1:0] GIG_MULT = 24'h00000a;

  typedef enum logic [1:0] {
    PIRL_SPD_10,
    PIRL_SPD_100,
    PIRL_SPD_1000
  } pirl_speed_e;

  typedef struct packed {
    logic port_based;
    logic pkt_mode;
  } pirl_ctrl_s;

  typedef struct packed {
    logic [IDX_PORT_W-1:0] port;
    logic [IDX_PRIO_W-1:0] prio;
  } pirl_query_s;

  typedef struct packed {
    logic unlimited;
    logic pkt_mode;
    logic [CODE_W-1:0] code;
    logic [RATE_W-1:0] rate;
  } pirl_limit_s;

endpackage

// File: pirl_rate_decode.sv
/*
  Combinational rate table: turns a 7-bit rate code, the link speed and
  the counting mode into a permitted rate (kbps or packets per second).
  Assumes the caller registers the result.
*/
`timescale 1ns/1ps
module pirl_rate_decode (
  input wire logic [pirl_pkg::CODE_W-1:0] code_i,
  input wire pirl_pkg::pirl_speed_e speed_i,
  input wire logic pkt_mode_i,
  output pirl_pkg::pirl_limit_s limit_o
);
  import pirl_pkg::*;

  logic [CODE_W-1:0] code;
  logic [RATE_W-1:0] c24;
  logic [RATE_W-1:0] fine;
  logic [RATE_W-1:0] fine_pkts;
  logic gig;

  always_comb begin
    // Undefined codes behave as code zero
    code = (code_i > CODE_DEF_MAX) ? CODE_FULL : code_i;
    c24 = {{(RATE_W-CODE_W){1'b0}}, code};
    fine = c24 - CODE_FINE_BASE;
    fine_pkts = (fine == 24'h000001) ? FINE_STEP : (fine - 24'h000001) * FINE_STEP * 24'h000002;
    gig = (speed_i == PIRL_SPD_1000) || (speed_i != PIRL_SPD_10 && speed_i != PIRL_SPD_100);
    limit_o.unlimited = 1'b0;
    limit_o.pkt_mode = pkt_mode_i;
    limit_o.code = code;
    limit_o.rate = '0;
    if (code == CODE_FULL) begin
      // Line rate for the link speed
      if (speed_i == PIRL_SPD_10) begin
        limit_o.rate = pkt_mode_i ? PKTS_10M : KBPS_10M;
      end else if (speed_i == PIRL_SPD_100) begin
        limit_o.rate = pkt_mode_i ? PKTS_100M : KBPS_100M;
      end else begin
        limit_o.rate = pkt_mode_i ? PKTS_1G : KBPS_1G;
      end
    end else if (code <= CODE_LOW_MAX) begin
      if (pkt_mode_i) begin
        limit_o.rate = gig ? c24 * PKTS_10M : c24 * PKTS_STEP;
      end else begin
        limit_o.rate = c24 * KBPS_1M;
      end
    end else if (code <= CODE_MID_MAX) begin
      if (speed_i == PIRL_SPD_10) begin
        // 10 Mbps link: full rate, no packet ceiling
        limit_o.unlimited = pkt_mode_i;
        limit_o.rate = pkt_mode_i ? '0 : KBPS_10M;
      end else if (pkt_mode_i) begin
        limit_o.rate = gig ? c24 * PKTS_10M : c24 * PKTS_STEP;
      end else begin
        limit_o.rate = gig ? c24 * KBPS_10M : c24 * KBPS_1M;
      end
    end else if (pkt_mode_i) begin
      limit_o.rate = gig ? fine_pkts * GIG_MULT : fine_pkts;
    end else if (speed_i == PIRL_SPD_10) begin
      limit_o.rate = fine * FINE_STEP;
    end else if (speed_i == PIRL_SPD_100 && fine > FINE_COARSE_MAX) begin
      limit_o.rate = fine * FINE_STEP;
    end else begin
      limit_o.rate = fine * FINE_STEP * GIG_MULT;
    end
  end

endmodule

// File: pirl_top.sv
/*
  Per-port, per-priority ingress rate limit configuration with a classic
  Wishbone slave and a one-cycle rate lookup for the metering path.
  Assumes a 10 MHz core clock, synchronous active-high reset and link
  speeds supplied by the port MACs.
*/
// Notes on behaviour
// - Ports 1..7 each hold eight 8-bit limit registers, one per priority.
// - Bits 6:0 are a read-write code reset to zero; bit 7 reads zero.
// - Priority 0..6 writes stay pending until priority 7 is written.
// - One shared table decodes the code by link speed and counting mode.
// - Packet mode uses the packets/s column, bit mode the bits/s column.
// - Code zero permits full line rate at the link speed.
// - Codes 1..10 give code times 1 Mbps, or code times the packet step (ten packet steps at 1000 Mbps).
// - Codes 11..100: 10 Mbps full rate, else code times the speed step.
// - 100 Mbps, codes 101..103 coarse, 104..115 fine; packets as 10 Mbps.
// - Per-port packet-mode bit selects packets when set, bits when clear.
// - Per-port bit selects port based when set, priority based when clear.
`timescale 1ns/1ps
module pirl_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [pirl_pkg::WB_ADR_W-1:0] wb_adr_i,
  input wire logic [pirl_pkg::WB_DAT_W-1:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [pirl_pkg::WB_DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire pirl_pkg::pirl_speed_e [pirl_pkg::PORT_CNT-1:0] link_speed_i,
  input wire logic query_valid_i,
  input wire pirl_pkg::pirl_query_s query_i,
  output logic limit_valid_o,
  output pirl_pkg::pirl_limit_s limit_o
);
  import pirl_pkg::*;

  typedef logic [PORT_CNT-1:0][PRIO_CNT-1:0][CODE_W-1:0] pirl_codes_t;

  // Bus decode
  logic [IDX_PORT_W-1:0] adr_port;
  logic [IDX_SUB_W-1:0] adr_sub;
  logic [IDX_PRIO_W-1:0] adr_prio;
  logic [2:0] pi;
  logic port_ok;
  logic hit_ctrl;
  logic hit_prio;
  logic hit_stat;
  logic bus_req;
  logic wr_en;
  logic wr_stage;
  logic wr_commit;

  logic ack_ff;
  logic nxt_ack;
  logic [WB_DAT_W-1:0] dat_ff;
  logic [WB_DAT_W-1:0] nxt_dat;

  pirl_codes_t staged_ff;
  pirl_codes_t nxt_staged;
  pirl_codes_t active_ff;
  pirl_codes_t nxt_active;
  pirl_ctrl_s [PORT_CNT-1:0] ctrl_ff;
  pirl_ctrl_s [PORT_CNT-1:0] nxt_ctrl;
  logic [PORT_CNT-1:0] pending_ff;
  logic [PORT_CNT-1:0] nxt_pending;

  always_comb begin
    adr_port = wb_adr_i[IDX_LSB+IDX_PORT_LSB +: IDX_PORT_W];
    adr_sub = wb_adr_i[IDX_LSB +: IDX_SUB_W];
    adr_prio = adr_sub[IDX_PRIO_W-1:0];
    pi = 3'(adr_port - PORT_FIRST);
    port_ok = (adr_port >= PORT_FIRST) && (adr_port <= PORT_LAST) && (wb_adr_i[1:0] == 2'h0);
    hit_ctrl = port_ok && (adr_sub == SUB_CTRL);
    // Eight consecutive indices per port
    hit_prio = port_ok && (adr_sub[IDX_SUB_W-1:IDX_PRIO_W] == SUB_PRIO0[IDX_SUB_W-1:IDX_PRIO_W]);
    hit_stat = port_ok && (adr_sub == SUB_STATUS);
    bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
    // Data lives in byte lane 0 only; other lanes alone write nothing
    wr_en = bus_req && wb_we_i && wb_sel_i[0];
    wr_stage = wr_en && hit_prio && (adr_prio != PRIO_COMMIT);
    wr_commit = wr_en && hit_prio && (adr_prio == PRIO_COMMIT);
  end

  // Bus answer: ack one cycle after the strobe, unmapped reads give zero
  always_comb begin
    nxt_ack = bus_req;
    nxt_dat = '0;
    if (bus_req && !wb_we_i) begin
      if (hit_prio) begin
        nxt_dat[CODE_W-1:0] = staged_ff[pi][adr_prio];
      end else if (hit_ctrl) begin
        nxt_dat[CTRL_PORT_BASED_BIT] = ctrl_ff[pi].port_based;
        nxt_dat[CTRL_PKT_MODE_BIT] = ctrl_ff[pi].pkt_mode;
      end else if (hit_stat) begin
        nxt_dat[STATUS_PENDING_BIT] = pending_ff[pi];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= '0;
    end else begin
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  // Configuration storage
  always_comb begin
    nxt_staged = staged_ff;
    nxt_active = active_ff;
    nxt_ctrl = ctrl_ff;
    nxt_pending = pending_ff;
    if (wr_stage) begin
      // Held back so a half-written priority set never meters frames
      nxt_staged[pi][adr_prio] = wb_dat_i[CODE_W-1:0];
      nxt_pending[pi] = 1'b1;
    end
    if (wr_commit) begin
      nxt_staged[pi][PRIO_COMMIT] = wb_dat_i[CODE_W-1:0];
      nxt_active[pi] = nxt_staged[pi];
      nxt_pending[pi] = 1'b0;
    end
    if (wr_en && hit_ctrl) begin
      nxt_ctrl[pi].port_based = wb_dat_i[CTRL_PORT_BASED_BIT];
      nxt_ctrl[pi].pkt_mode = wb_dat_i[CTRL_PKT_MODE_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      staged_ff <= {(PORT_CNT*PRIO_CNT){CODE_RESET}};
      active_ff <= {(PORT_CNT*PRIO_CNT){CODE_RESET}};
      ctrl_ff <= '0;
      pending_ff <= '0;
    end else begin
      staged_ff <= nxt_staged;
      active_ff <= nxt_active;
      ctrl_ff <= nxt_ctrl;
      pending_ff <= nxt_pending;
    end
  end

  // Rate lookup for the metering path
  logic [2:0] qi;
  logic q_ok;
  logic [CODE_W-1:0] q_code;
  pirl_speed_e q_speed;
  logic q_pkt;
  pirl_limit_s dec_limit;
  logic lim_vld_ff;
  logic nxt_lim_vld;
  pirl_limit_s lim_ff;
  pirl_limit_s nxt_lim;

  always_comb begin
    q_ok = (query_i.port >= PORT_FIRST) && (query_i.port <= PORT_LAST);
    qi = q_ok ? 3'(query_i.port - PORT_FIRST) : 3'h0;
    q_speed = link_speed_i[qi];
    q_pkt = ctrl_ff[qi].pkt_mode;
    // Port based uses priority 0's code for every frame
    if (ctrl_ff[qi].port_based) begin
      q_code = active_ff[qi][0];
    end else begin
      q_code = active_ff[qi][query_i.prio];
    end
  end

  pirl_rate_decode u_decode (
    .code_i(q_code),
    .speed_i(q_speed),
    .pkt_mode_i(q_pkt),
    .limit_o(dec_limit)
  );

  always_comb begin
    nxt_lim_vld = query_valid_i;
    nxt_lim = lim_ff;
    if (query_valid_i) begin
      if (q_ok) begin
        nxt_lim = dec_limit;
      end else begin
        // Unknown port: nothing to limit against
        nxt_lim = '0;
        nxt_lim.unlimited = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lim_vld_ff <= 1'b0;
      lim_ff <= '0;
    end else begin
      lim_vld_ff <= nxt_lim_vld;
      lim_ff <= nxt_lim;
    end
  end

  assign limit_valid_o = lim_vld_ff;
  assign limit_o = lim_ff;

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic q_bit;
  assign q_bit = query_valid_i && q_ok && !q_pkt;

  a_read_reserved_zero: assert property (
    (bus_req && !wb_we_i && hit_prio) |=> wb_ack_o && (wb_dat_o[WB_DAT_W-1:CODE_W] == '0))
    else $error("reserved read bits not zero");
  a_stage_no_apply: assert property (
    wr_stage |=> $stable(active_ff) && pending_ff[$past(pi)])
    else $error("staged write changed applied codes");
  a_commit_applies: assert property (
    wr_commit |=> (active_ff[$past(pi)] == staged_ff[$past(pi)]) && !pending_ff[$past(pi)])
    else $error("commit did not apply staged codes");
  a_zero_full_rate: assert property (
    (q_bit && q_code == CODE_FULL && q_speed == PIRL_SPD_1000)
      |=> limit_valid_o && limit_o.rate == KBPS_1G)
    else $error("code zero not line rate");
  a_low_code_bits: assert property (
    (q_bit && q_code != CODE_FULL && q_code <= CODE_LOW_MAX)
      |=> limit_o.rate == 24'($past(q_code)) * KBPS_1M)
    else $error("low code bit rate wrong");
  a_ten_pkt_unlimited: assert property (
    (query_valid_i && q_ok && q_pkt && q_speed == PIRL_SPD_10 && q_code > CODE_LOW_MAX
      && q_code <= CODE_MID_MAX) |=> limit_o.unlimited)
    else $error("10M mid code not unlimited");
  a_undef_as_zero: assert property (
    (q_bit && q_code > CODE_DEF_MAX && q_speed == PIRL_SPD_10)
      |=> limit_o.rate == KBPS_10M && limit_o.code == CODE_FULL)
    else $error("undefined code not treated as zero");
  a_mode_follows: assert property (
    (query_valid_i && q_ok) |=> limit_o.pkt_mode == $past(q_pkt))
    else $error("counting mode mismatch");
  a_port_based_code: assert property (
    (query_valid_i && q_ok && ctrl_ff[qi].port_based)
      |=> limit_o.code == $past(active_ff[qi][0]) || $past(q_code) > CODE_DEF_MAX)
    else $error("port based mode used wrong code");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

  c_commit: cover property (wr_commit);
  c_stage_then_commit: cover property (wr_stage ##[1:20] wr_commit);
  c_pkt_query: cover property (query_valid_i && q_ok && q_pkt);
  c_port_based: cover property (query_valid_i && q_ok && ctrl_ff[qi].port_based);

endmodule

// File: pirl_top_test.sv
/*
  Self-checking bench for the rate limit block: register access over
  classic Wishbone, staged commit, rate table sweep and the lookup port.
  Assumes pirl_pkg and pirl_top are compiled first.
*/
`timescale 1ns/1ps
module pirl_top_test;
  import pirl_pkg::*;
  localparam logic [CODE_W-1:0] SWEEP [13] = '{7'h00, 7'h01, 7'h0a, 7'h0b, 7'h32, 7'h64,
    7'h65, 7'h66, 7'h67, 7'h68, 7'h73, 7'h74, 7'h7f};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [WB_ADR_W-1:0] wb_adr = '0;
  logic [WB_DAT_W-1:0] wb_dat = '0;
  logic [3:0] wb_sel = '0;
  logic wb_we = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic [WB_DAT_W-1:0] wb_dat_o;
  logic wb_ack_o;
  pirl_speed_e [PORT_CNT-1:0] spd;
  logic query_valid = 1'b0;
  pirl_query_s query = '0;
  logic limit_valid_o;
  pirl_limit_s limit_o;
  int err_total = 0;
  int comparisons = 0;

  always #50 clk_i = ~clk_i;

  pirl_top pirl_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
    .wb_sel_i(wb_sel), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link_speed_i(spd),
    .query_valid_i(query_valid), .query_i(query), .limit_valid_o(limit_valid_o),
    .limit_o(limit_o));

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Entered just after a rising edge; returns one idle edge after the ack
  task automatic wb_xfer(input logic we, input logic [WB_ADR_W-1:0] adr,
      input logic [WB_DAT_W-1:0] d, input logic [3:0] sel, output logic [WB_DAT_W-1:0] r);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat <= d;
    wb_sel <= sel;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    chk("wb_ack", 64'(wb_ack_o), 64'h1);
    r = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [IDX_PORT_W-1:0] pt, input logic [IDX_SUB_W-1:0] sub,
      input logic [WB_DAT_W-1:0] d);
    logic [WB_DAT_W-1:0] r;
    wb_xfer(1'b1, {pt, sub, 2'b00}, d, 4'hf, r);
  endtask

  task automatic rdchk(input string what, input logic [IDX_PORT_W-1:0] pt,
      input logic [IDX_SUB_W-1:0] sub, input logic [WB_DAT_W-1:0] e);
    logic [WB_DAT_W-1:0] r;
    wb_xfer(1'b0, {pt, sub, 2'b00}, '0, 4'hf, r);
    chk(what, 64'(r), 64'(e));
  endtask

  function automatic pirl_limit_s exp_lim(logic [CODE_W-1:0] c, pirl_speed_e s, logic p);
    pirl_limit_s e;
    logic [RATE_W-1:0] k;
    logic [RATE_W-1:0] g;
    e = '0;
    e.pkt_mode = p;
    if (c > CODE_DEF_MAX) c = CODE_FULL;
    e.code = c;
    g = (s == PIRL_SPD_10 || s == PIRL_SPD_100) ? 24'h000001 : GIG_MULT;
    k = RATE_W'(c);
    if (c == CODE_FULL) begin
      case (s)
        PIRL_SPD_10: e.rate = p ? PKTS_10M : KBPS_10M;
        PIRL_SPD_100: e.rate = p ? PKTS_100M : KBPS_100M;
        default: e.rate = p ? PKTS_1G : KBPS_1G;
      endcase
    end else if (c <= CODE_LOW_MAX) begin
      e.rate = p ? k * PKTS_STEP * g : k * KBPS_1M;
    end else if (c <= CODE_MID_MAX) begin
      if (s == PIRL_SPD_10) begin
        e.unlimited = p;
        e.rate = p ? 24'h000000 : KBPS_10M;
      end else begin
        e.rate = p ? k * PKTS_STEP * g : k * KBPS_1M * g;
      end
    end else begin
      k = k - CODE_FINE_BASE;
      if (p) begin
        e.rate = g * ((k == 24'h000001) ? FINE_STEP : (k - 24'h000001) * FINE_STEP * 24'h000002);
      end else if (g == GIG_MULT || (s == PIRL_SPD_100 && k <= FINE_COARSE_MAX)) begin
        e.rate = k * FINE_STEP * GIG_MULT;
      end else begin
        e.rate = k * FINE_STEP;
      end
    end
    return e;
  endfunction

  task automatic query_chk(input logic [IDX_PORT_W-1:0] pt, input logic [IDX_PRIO_W-1:0] pr,
      input pirl_limit_s e);
    query_valid <= 1'b1;
    query <= '{port: pt, prio: pr};
    @(posedge clk_i);
    query_valid <= 1'b0;
    @(posedge clk_i);
    chk("limit_valid", 64'(limit_valid_o), 64'h1);
    chk("limit_code_rate", 64'({limit_o.code, limit_o.rate}), 64'({e.code, e.rate}));
    chk("limit_flags", 64'({limit_o.unlimited, limit_o.pkt_mode}), 64'({e.unlimited, e.pkt_mode}));
  endtask

  task automatic t_reset();
    chk("limit_after_reset", 64'(limit_o), 64'h0);
    for (int pr = 0; pr < PRIO_CNT; pr++) begin
      rdchk("code_p1_reset", PORT_FIRST, SUB_PRIO0 + IDX_SUB_W'(pr), 32'h0);
      rdchk("code_p7_reset", PORT_LAST, SUB_PRIO0 + IDX_SUB_W'(pr), 32'h0);
    end
  endtask

  task automatic t_access();
    logic [WB_DAT_W-1:0] r;
    wr(4'h2, SUB_PRIO0 + 12'h003, 32'hffffffff);
    rdchk("code_reserved_bit", 4'h2, SUB_PRIO0 + 12'h003, 32'h7f);
    wb_xfer(1'b1, {4'h2, SUB_PRIO0 + 12'h003, 2'b00}, 32'h11, 4'he, r);
    rdchk("code_sel_off", 4'h2, SUB_PRIO0 + 12'h003, 32'h7f);
    // Unmapped places: port 0, beyond the last priority, unaligned byte
    wr(4'h0, SUB_PRIO0, 32'h55);
    rdchk("unmapped_port0", 4'h0, SUB_PRIO0, 32'h0);
    rdchk("unmapped_sub", 4'h2, SUB_PRIO0 + 12'h00f, 32'h0);
    wb_xfer(1'b0, {4'h2, SUB_PRIO0 + 12'h003, 2'b01}, '0, 4'hf, r);
    chk("unaligned_read", 64'(r), 64'h0);
  endtask

  task automatic t_stage();
    spd[2] <= PIRL_SPD_100;
    for (int pr = 0; pr < PRIO_CNT - 1; pr++) wr(4'h3, SUB_PRIO0 + IDX_SUB_W'(pr), 32'(pr + 1));
    rdchk("pending_set", 4'h3, SUB_STATUS, 32'h1 << STATUS_PENDING_BIT);
    rdchk("staged_readback", 4'h3, SUB_PRIO0 + 12'h002, 32'h3);
    query_chk(4'h3, 3'h2, exp_lim(7'h00, PIRL_SPD_100, 1'b0));
    wr(4'h3, SUB_PRIO0 + 12'h007, 32'h8);
    rdchk("pending_clear", 4'h3, SUB_STATUS, 32'h0);
    for (int pr = 0; pr < PRIO_CNT; pr++) begin
      query_chk(4'h3, pr[2:0], exp_lim(CODE_W'(pr + 1), PIRL_SPD_100, 1'b0));
    end
  endtask

  task automatic t_sweep();
    // Speed code 3 has no name and must decode as 1000 Mbps
    for (int s = 0; s < 4; s++) begin
      for (int m = 0; m < 2; m++) begin
        spd[3] <= pirl_speed_e'(s);
        wr(4'h4, SUB_CTRL, 32'(m) << CTRL_PKT_MODE_BIT);
        rdchk("ctrl_readback", 4'h4, SUB_CTRL, 32'(m) << CTRL_PKT_MODE_BIT);
        for (int i = 0; i < 13; i++) begin
          wr(4'h4, SUB_PRIO0 + 12'h007, 32'(SWEEP[i]));
          query_chk(4'h4, 3'h7, exp_lim(SWEEP[i], pirl_speed_e'(s), m[0]));
        end
      end
    end
  endtask

  task automatic t_port_based();
    wr(4'h5, SUB_PRIO0, 32'h5);
    wr(4'h5, SUB_PRIO0 + 12'h007, 32'h14);
    wr(4'h5, SUB_CTRL, 32'h1 << CTRL_PORT_BASED_BIT);
    query_chk(4'h5, 3'h7, exp_lim(7'h05, PIRL_SPD_10, 1'b0));
    wr(4'h5, SUB_CTRL, 32'h0);
    query_chk(4'h5, 3'h7, exp_lim(7'h14, PIRL_SPD_10, 1'b0));
  endtask

  task automatic t_bad_port();
    pirl_limit_s e;
    e = '0;
    e.unlimited = 1'b1;
    query_chk(4'h0, 3'h1, e);
    query_chk(4'h8, 3'h1, e);
  endtask

  initial begin
    foreach (spd[i]) spd[i] = PIRL_SPD_10;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_access();
    t_stage();
    t_sweep();
    t_port_based();
    t_bad_port();
    tally_and_finish();
  end

  // Whole run needs roughly 710 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    tally_and_finish();
  end
endmodule
